// File: design/vdl_pkg.sv
// Package for the vector delay line: register map, field layout,
// structural segment length and lane latency arithmetic.
// Assumes a single 50 MHz clock domain and an APB master outside.
//
// Function
// - Every input word appears on the output exactly L cycles later; the output FIFO here adds 2, so L+2 cycles when nothing stalls.
// - Output sample rate and data type equal those of the input.
// - All delay stages start at zero and no other start value exists.
// - The synchronous reset returns every delay stage to zero.
// - The synchronous reset clears the stages even while enable is low.
// - With enable low every delay stage holds until enable or reset.
// - Only non-negative whole-cycle latencies are accepted.
// - Zero latency is allowed only when the enable port is not used.
// - Zero latency is a plain wire from input to output.
// - Latency one is a single flip-flop stage per data bit.
// - A delay is a shift chain of L-1 cycles then one output flop.
// - Latencies above 33 cascade several shift-chain-plus-flop segments.
// - Several parallel lanes are processed every sample period.
// - In per-lane mode lane i is delayed by base plus step times (i-1).
// - The per-lane step may not give any lane a negative delay.
package vdl_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int          APB_ADDR_W     = 8;
    localparam logic [7:0]  ADDR_CTRL      = 8'h00;
    localparam logic [7:0]  ADDR_STATUS    = 8'h04;
    localparam logic [7:0]  ADDR_CONFIG    = 8'h08;
    localparam logic [7:0]  ADDR_OUT_COUNT = 8'h0C;

    localparam int          CTRL_RUN_BIT   = 0;
    localparam int          CTRL_CLEAR_BIT = 1;
    localparam logic        CTRL_RUN_RST   = 1'b1;

    localparam int          STAT_EMPTY_BIT = 0;
    localparam int          STAT_FULL_BIT  = 1;
    localparam int          STAT_LEVEL_LSB = 8;

    localparam int          CFG_LAT_LSB    = 0;
    localparam int          CFG_STEP_LSB   = 16;
    localparam int          CFG_LANE_LSB   = 24;

    localparam logic [31:0] WORD_ZERO      = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Structural delay segment length
    // ------------------------------------------------------------------
    localparam int          SEG_LEN        = 33;

    function automatic int vdl_lane_lat(input int base, input int step,
                                        input int lane);
        return base + step * lane;
    endfunction : vdl_lane_lat

    function automatic int vdl_min(input int a, input int b);
        return (a < b) ? a : b;
    endfunction : vdl_min

endpackage : vdl_pkg

// File: design/vdl_top.sv
// Vector delay line: per-lane fixed delays, an output FIFO and an APB
// register slave. All logic sits on sys_clk; ce freezes every state.
// Assumes upstream and downstream logic on the same clock.
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// One structural segment: shift chain of LEN-1 words then one flop
// ----------------------------------------------------------------------
module vdl_seg
    import vdl_pkg::*;
#(
    parameter int W   = 16,
    parameter int LEN = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         clr,
    input  wire logic         adv,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] shift_r [LEN];

    always_ff @(posedge sys_clk) begin
        if (clr) begin
            for (int i = 0; i < LEN; i++) begin
                shift_r[i] <= '0;
            end
        end else if (adv) begin
            shift_r[0] <= d;
            for (int i = 1; i < LEN; i++) begin
                shift_r[i] <= shift_r[i-1];
            end
        end
    end

    assign q = shift_r[LEN-1];
endmodule : vdl_seg

// ----------------------------------------------------------------------
// One lane: segments of at most SEG_LEN stages in series
// ----------------------------------------------------------------------
module vdl_chain
    import vdl_pkg::*;
#(
    parameter int W   = 16,
    parameter int LAT = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         clr,
    input  wire logic         adv,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    generate
        if (LAT == 0) begin : g_wire
            assign q = d;
        end else begin : g_segs
            localparam int NSEG = (LAT + SEG_LEN - 1) / SEG_LEN;
            logic [W-1:0] link [NSEG+1];
            assign link[0] = d;
            for (genvar k = 0; k < NSEG; k++) begin : g_seg
                // Segments are chained by plain routing, no cascade path
                vdl_seg #(
                    .W   (W),
                    .LEN (vdl_min(SEG_LEN, LAT - k * SEG_LEN))
                ) u_seg (
                    .sys_clk (sys_clk),
                    .clr     (clr),
                    .adv     (adv),
                    .d       (link[k]),
                    .q       (link[k+1])
                );
            end
            assign q = link[NSEG];
        end
    endgenerate
endmodule : vdl_chain

// ----------------------------------------------------------------------
// FIFO with registered output stage and registered in_ready
// ----------------------------------------------------------------------
module vdl_fifo #(
    parameter int W     = 64,
    parameter int DEPTH = 8,
    parameter int CNT_W = $clog2(DEPTH + 1)
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic             in_valid,
    output var  logic             in_ready,
    input  wire logic [W-1:0]     in_data,
    output var  logic             out_valid,
    input  wire logic             out_ready,
    output var  logic [W-1:0]     out_data,
    output var  logic [CNT_W-1:0] level
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

    logic [W-1:0]     mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_r;
    logic [PTR_W-1:0] rd_ptr_r;
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    logic             in_ready_r;
    logic             out_valid_r;
    logic [W-1:0]     out_data_r;
    logic             push;
    logic             pop;

    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        return (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : ptr_inc

    assign push = ce & in_valid & in_ready_r;
    assign pop  = ce & (count_r != '0) & (~out_valid_r | out_ready);

    always_comb begin
        count_nxt = count_r;
        if (push & ~pop) begin
            count_nxt = count_r + 1'b1;
        end else if (pop & ~push) begin
            count_nxt = count_r - 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wr_ptr_r   <= '0;
            rd_ptr_r   <= '0;
            count_r    <= '0;
            in_ready_r <= 1'b0;
        end else if (ce) begin
            if (push) begin
                wr_ptr_r <= ptr_inc(wr_ptr_r);
            end
            if (pop) begin
                rd_ptr_r <= ptr_inc(rd_ptr_r);
            end
            count_r    <= count_nxt;
            in_ready_r <= (count_nxt < FULL_CNT);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            out_valid_r <= 1'b0;
            out_data_r  <= '0;
        end else if (ce) begin
            if (pop) begin
                out_valid_r <= 1'b1;
                out_data_r  <= mem[rd_ptr_r];
            end else if (out_ready) begin
                out_valid_r <= 1'b0;
            end
        end
    end

    assign in_ready  = in_ready_r;
    assign out_valid = out_valid_r;
    assign out_data  = out_data_r;
    assign level     = count_r;
endmodule : vdl_fifo

// ----------------------------------------------------------------------
// Top level
// ----------------------------------------------------------------------
module vdl_top
    import vdl_pkg::*;
#(
    parameter int DATA_W              = 16,
    parameter int PARALLEL_LANE_COUNT = 4,
    parameter int LATENCY             = 4,
    parameter int LANE_STEP           = 0,
    parameter bit USE_EN              = 1'b1,
    parameter bit USE_SRST            = 1'b1,
    parameter int FIFO_DEPTH          = 8
) (
    input  wire logic                                  sys_clk,
    input  wire logic                                  rst,
    input  wire logic                                  ce,
    input  wire logic                                  srst,
    input  wire logic                                  en,
    input  wire logic                                  in_valid,
    input  wire logic [PARALLEL_LANE_COUNT*DATA_W-1:0] in_data,
    output var  logic                                  line_ready,
    output var  logic                                  out_valid,
    input  wire logic                                  out_ready,
    output var  logic [PARALLEL_LANE_COUNT*DATA_W-1:0] out_data,
    input  wire logic                                  psel,
    input  wire logic                                  penable,
    input  wire logic                                  pwrite,
    input  wire logic [APB_ADDR_W-1:0]                 paddr,
    input  wire logic [31:0]                           pwdata,
    output var  logic [31:0]                           prdata,
    output var  logic                                  pready,
    output var  logic                                  pslverr
);
    localparam int VW    = PARALLEL_LANE_COUNT * DATA_W;
    localparam int CNT_W = $clog2(FIFO_DEPTH + 1);

    // ------------------------------------------------------------------
    // Configuration checks at elaboration
    // ------------------------------------------------------------------
    generate
        if (LATENCY < 0) begin : g_bad_lat
            $error("vdl_top: latency must be non-negative");
        end
        if (USE_EN && LATENCY == 0) begin : g_bad_en
            $error("vdl_top: zero latency needs the enable unused");
        end
        if (vdl_lane_lat(LATENCY, LANE_STEP,
                         PARALLEL_LANE_COUNT - 1) < 0) begin : g_bad_step
            $error("vdl_top: lane step gives a negative delay");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Control
    // ------------------------------------------------------------------
    logic             run_r;
    logic             clear_r;
    logic [31:0]      out_count_r;
    logic [31:0]      prdata_r;
    logic             pready_r;
    logic             pslverr_r;
    logic             fifo_ready;
    logic [CNT_W-1:0] fifo_level;
    logic             en_ok;
    logic             adv;
    logic             clr;
    logic             apb_do;
    logic [VW-1:0]    dly_data;
    logic             dly_valid;

    // The enable is a plain same-clock level from the datapath
    assign en_ok = USE_EN ? en : 1'b1;
    // Stall on a full FIFO so no delayed word is dropped for lack of room
    assign adv   = ce & en_ok & run_r & fifo_ready;
    // Clear beats enable, run and back-pressure alike
    assign clr   = rst | (ce & ((USE_SRST & srst) | clear_r));

    // ------------------------------------------------------------------
    // Delay lanes
    // ------------------------------------------------------------------
    generate
        for (genvar i = 0; i < PARALLEL_LANE_COUNT; i++) begin : g_lane
            vdl_chain #(
                .W   (DATA_W),
                .LAT (vdl_lane_lat(LATENCY, LANE_STEP, i))
            ) u_lane (
                .sys_clk (sys_clk),
                .clr     (clr),
                .adv     (adv),
                .d       (in_data[i*DATA_W +: DATA_W]),
                .q       (dly_data[i*DATA_W +: DATA_W])
            );
        end
    endgenerate

    // Valid follows the base latency so word marking stays aligned
    vdl_chain #(
        .W   (1),
        .LAT (LATENCY)
    ) u_valid (
        .sys_clk (sys_clk),
        .clr     (clr),
        .adv     (adv),
        .d       (in_valid),
        .q       (dly_valid)
    );

    vdl_fifo #(
        .W     (VW),
        .DEPTH (FIFO_DEPTH),
        .CNT_W (CNT_W)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .ce        (ce),
        // A word at the line's end is dropped when a clear hits that edge
        .in_valid  (dly_valid & adv & ~clr),
        .in_ready  (fifo_ready),
        .in_data   (dly_data),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (out_data),
        .level     (fifo_level)
    );

    assign line_ready = fifo_ready;

    // ------------------------------------------------------------------
    // APB slave: one wait state, answer registered
    // ------------------------------------------------------------------
    assign apb_do = psel & penable & pready_r;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pready_r <= 1'b0;
        end else if (ce) begin
            pready_r <= psel & penable & ~pready_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prdata_r  <= WORD_ZERO;
            pslverr_r <= 1'b0;
        end else if (ce && psel && penable && !pready_r) begin
            prdata_r  <= WORD_ZERO;
            pslverr_r <= 1'b0;
            case (paddr)
                ADDR_CTRL: begin
                    prdata_r[CTRL_RUN_BIT] <= run_r;
                end
                ADDR_STATUS: begin
                    prdata_r[STAT_EMPTY_BIT] <= (fifo_level == '0);
                    prdata_r[STAT_FULL_BIT]  <= ~fifo_ready;
                    prdata_r[STAT_LEVEL_LSB +: CNT_W] <= fifo_level;
                end
                ADDR_CONFIG: begin
                    if (!pwrite) begin
                        prdata_r[CFG_LAT_LSB +: 16]  <= 16'(LATENCY);
                        prdata_r[CFG_STEP_LSB +: 8]  <= 8'(LANE_STEP);
                        prdata_r[CFG_LANE_LSB +: 8]  <=
                            8'(PARALLEL_LANE_COUNT);
                    end else begin
                        pslverr_r <= 1'b1;
                    end
                end
                ADDR_OUT_COUNT: begin
                    prdata_r <= out_count_r;
                end
                default: begin
                    pslverr_r <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            run_r <= CTRL_RUN_RST;
        end else if (ce && apb_do && pwrite && paddr == ADDR_CTRL) begin
            run_r <= pwdata[CTRL_RUN_BIT];
        end
    end

    // Clear is a one-cycle pulse; it reads back as zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            clear_r <= 1'b0;
        end else if (ce) begin
            clear_r <= apb_do & pwrite & (paddr == ADDR_CTRL)
                       & pwdata[CTRL_CLEAR_BIT];
        end
    end

    // Any write to the counter zeroes it; a delivery in that cycle then counts as one
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            out_count_r <= WORD_ZERO;
        end else if (ce) begin
            if (out_valid && out_ready) begin
                if (apb_do && pwrite && paddr == ADDR_OUT_COUNT) begin
                    out_count_r <= 32'h0000_0001;
                end else begin
                    out_count_r <= out_count_r + 1'b1;
                end
            end else if (apb_do && pwrite && paddr == ADDR_OUT_COUNT) begin
                out_count_r <= WORD_ZERO;
            end
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;
endmodule : vdl_top

`default_nettype wire

// File: verif/vdl_properties.sv
// Port checker for vdl_top: reset, output hold, freeze, APB answers.
// Bound to vdl_top; one clock, rst synchronous and active high.
`timescale 1ns/1ps
`default_nettype none

module vdl_properties
    import vdl_pkg::*;
#(
    parameter int DATA_W              = 16,
    parameter int PARALLEL_LANE_COUNT = 4,
    parameter int LATENCY             = 4,
    parameter int LANE_STEP           = 0
) (
    input wire logic                                  sys_clk,
    input wire logic                                  rst,
    input wire logic                                  ce,
    input wire logic                                  out_valid,
    input wire logic                                  out_ready,
    input wire logic [PARALLEL_LANE_COUNT*DATA_W-1:0] out_data,
    input wire logic                                  psel,
    input wire logic                                  penable,
    input wire logic                                  pwrite,
    input wire logic [APB_ADDR_W-1:0]                 paddr,
    input wire logic [31:0]                           prdata,
    input wire logic                                  pready,
    input wire logic                                  pslverr
);
    localparam logic [31:0] CFG = {8'(PARALLEL_LANE_COUNT),
                                   8'(LANE_STEP), 16'(LATENCY)};
    wire logic acc = psel && penable && pready;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    rst_clear_a:
        assert property (disable iff (1'b0)
            rst |=> !out_valid && out_data == '0 && !pready)
        else $error("reset left output or bus active");
    out_hold_a:
        assert property (out_valid && !out_ready
            |=> out_valid && $stable(out_data))
        else $error("output word dropped before taken");
    quiet_start_a:
        assert property ($fell(rst) |-> !out_valid [*6])
        else $error("output word too soon after reset");
    ce_freeze_a:
        assert property (!ce |=> $stable(out_valid) && $stable(out_data))
        else $error("state moved while clock enable low");
    apb_wait_a:
        assert property (ce && psel && penable && !pready |=> pready)
        else $error("bus answer not after one wait state");
    pready_pulse_a:
        assert property (pready |=> !pready)
        else $error("ready held past one cycle");
    pready_acc_a:
        assert property (pready |-> psel && penable)
        else $error("ready outside an access phase");
    unmapped_err_a:
        assert property (acc && (paddr > 8'h0C || paddr[1:0] != 2'h0)
            |-> pslverr && prdata == '0)
        else $error("unmapped address not refused");
    cfg_ro_a:
        assert property (acc && pwrite && paddr == ADDR_CONFIG |-> pslverr)
        else $error("write to read-only config accepted");
    cfg_read_a:
        assert property (acc && !pwrite && paddr == ADDR_CONFIG
            |-> !pslverr && prdata == CFG)
        else $error("config word wrong");
endmodule : vdl_properties

bind vdl_top vdl_properties #(
    .DATA_W              (DATA_W),
    .PARALLEL_LANE_COUNT (PARALLEL_LANE_COUNT),
    .LATENCY             (LATENCY),
    .LANE_STEP           (LANE_STEP)
) i_props (
    .sys_clk, .rst, .ce, .out_valid, .out_ready, .out_data, .psel,
    .penable, .pwrite, .paddr, .prdata, .pready, .pslverr
);

`default_nettype wire

// File: verif/vdl_sink.sv
// Downstream consumer model for the delay line output.
// Same clock; prompt, stalled or every-other-cycle as commanded.
`timescale 1ns/1ps
`default_nettype none

module vdl_sink (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic stall,
    input  wire logic slow,
    output var  logic out_ready
);
    logic tog_r;

    always_ff @(posedge sys_clk) begin
        tog_r <= rst ? 1'b0 : !tog_r;
    end

    // Slow mode takes at most one word in two cycles
    assign out_ready = !rst && !stall && (!slow || tog_r);
endmodule : vdl_sink

`default_nettype wire

// File: verif/tb_vector_delay_line.sv
// Self-checking bench for vdl_top with a downstream sink model.
// Inputs change at rising edges; the scoreboard follows each advance.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
    $display("BAD %0t got %0h want %0h", $time, a, b); end end

module tb_vector_delay_line
    import vdl_pkg::*;
;
    localparam int DW  = 16;
    localparam int NL  = 4;
    localparam int LAT = 4;
    localparam int STP = 1;
    localparam int W   = NL * DW;
    logic          sys_clk = 1'b0, rst = 1'b1, ce = 1'b1;
    logic          srst = 1'b0, en = 1'b1, in_valid = 1'b0;
    logic          line_ready, out_valid, out_ready, pready, pslverr;
    logic [W-1:0]  in_data = '0, out_data, want;
    logic          psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]    paddr = 8'h00;
    logic [31:0]   pwdata = 32'h0, prdata, r;
    logic          stall = 1'b0, slow = 1'b0, run_m = 1'b1, clr_m = 1'b0;
    logic          hv[$];
    logic [W-1:0]  hd[$], exp_q[$];
    int            fails = 0, cmp_count = 0, cyc = 0, ndel = 0;

    always #10 sys_clk = !sys_clk;

    vdl_top #(.DATA_W(DW), .PARALLEL_LANE_COUNT(NL), .LATENCY(LAT),
              .LANE_STEP(STP)) i_dut (.sys_clk, .rst, .ce, .srst, .en,
        .in_valid, .in_data, .line_ready, .out_valid, .out_ready,
        .out_data, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr);
    vdl_sink i_snk (.sys_clk, .rst, .stall, .slow, .out_ready);

    function automatic logic [W-1:0] dat(input int k);
        for (int i = 0; i < NL; i++) dat[i*DW +: DW] = DW'(k * 8 + i + 1);
    endfunction : dat

    // Lane i holds the sample taken STP*i advances earlier, zero before
    function automatic logic [W-1:0] expw(input int k);
        logic [W-1:0] v = '0;
        for (int i = 0; i < NL; i++)
            if (k - STP * i >= 0) v[i*DW +: DW] = hd[k-STP*i][i*DW +: DW];
        return v;
    endfunction : expw

    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_of_test

    // ------------------------------------------------------------
    // Scoreboard
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        cyc++;
        if (rst || (ce && (srst || clr_m))) begin
            hv.delete();
            hd.delete();
        end else if (ce && en && run_m && line_ready) begin
            hv.push_back(in_valid);
            hd.push_back(in_data);
            if (hd.size() > LAT && hv[hd.size() - 1 - LAT])
                exp_q.push_back(expw(hd.size() - 1 - LAT));
        end
        if (psel && penable && pready && pwrite && paddr == ADDR_CTRL)
            run_m <= pwdata[CTRL_RUN_BIT];
        // The clear pulse reaches the stages one edge after the write
        if (ce)
            clr_m <= psel && penable && pready && pwrite
                     && paddr == ADDR_CTRL && pwdata[CTRL_CLEAR_BIT];
        if (rst) begin
            run_m <= CTRL_RUN_RST;
            clr_m <= 1'b0;
        end
        if (ce && out_valid && out_ready) begin
            ndel++;
            want = exp_q.size() ? exp_q.pop_front() : {W{1'bx}};
            `CHK(out_data, want)
        end
        if (cyc == 20000) begin
            fails++;
            end_of_test();
        end
    end

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // Only the bench timeout ends a transfer that is never answered
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        r = prdata;
        `CHK(pslverr, e)
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : bus

    task automatic send(input int n, input int base);
        int t;
        for (int k = 0; k < n; k++) begin
            t = 0;
            in_valid <= 1'b1;
            in_data <= dat(base + k);
            do begin
                @(posedge sys_clk);
                t++;
            end while (!(ce && en && run_m && line_ready && !srst && !clr_m)
                       && t < 200);
        end
        in_valid <= 1'b0;
    endtask : send

    task automatic drain();
        int n;
        n = 0;
        repeat (LAT + 2 * NL) @(posedge sys_clk);
        while ((exp_q.size() != 0 || out_valid !== 1'b0) && n < 300) begin
            @(posedge sys_clk);
            n++;
        end
        `CHK(exp_q.size(), 0)
    endtask : drain

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_lat();
        int n;
        send(1, 100);
        n = 0;
        while (out_valid !== 1'b1 && n < 50) begin
            @(posedge sys_clk);
            n++;
        end
        // Seen one edge after it rises
        `CHK(n, LAT + 2)
        drain();
    endtask : t_lat

    task automatic t_regs();
        bus(1'b0, ADDR_CTRL, 32'h0, 1'b0);
        `CHK(r, 32'h0000_0001)
        bus(1'b0, ADDR_CONFIG, 32'h0, 1'b0);
        `CHK(r, {8'(NL), 8'(STP), 16'(LAT)})
        bus(1'b0, ADDR_STATUS, 32'h0, 1'b0);
        `CHK(r, 32'h0000_0001)
        bus(1'b0, 8'h10, 32'h0, 1'b1);
        `CHK(r, 32'h0000_0000)
        bus(1'b1, ADDR_CONFIG, 32'hFFFF_FFFF, 1'b1);
    endtask : t_regs

    task automatic t_stream();
        srst <= 1'b1;
        @(posedge sys_clk);
        srst <= 1'b0;
        slow <= 1'b1;
        send(12, 0);
        drain();
        slow <= 1'b0;
    endtask : t_stream

    task automatic t_freeze();
        fork
            send(10, 200);
            begin
                repeat (4) @(posedge sys_clk);
                en <= 1'b0;
                repeat (4) @(posedge sys_clk);
                srst <= 1'b1;
                @(posedge sys_clk);
                srst <= 1'b0;
                en <= 1'b1;
                repeat (3) @(posedge sys_clk);
                ce <= 1'b0;
                repeat (3) @(posedge sys_clk);
                ce <= 1'b1;
            end
        join
        drain();
    endtask : t_freeze

    task automatic t_buf();
        stall <= 1'b1;
        fork
            send(14, 300);
            begin
                repeat (30) @(posedge sys_clk);
                `CHK(line_ready, 1'b0)
                bus(1'b0, ADDR_STATUS, 32'h0, 1'b0);
                `CHK(r[STAT_FULL_BIT +: 1], 1'b1)
                stall <= 1'b0;
            end
        join
        drain();
        bus(1'b0, ADDR_OUT_COUNT, 32'h0, 1'b0);
        `CHK(r, 32'(ndel))
        bus(1'b1, ADDR_OUT_COUNT, 32'h0, 1'b0);
        bus(1'b0, ADDR_OUT_COUNT, 32'h0, 1'b0);
        `CHK(r, 32'h0000_0000)
        bus(1'b0, ADDR_STATUS, 32'h0, 1'b0);
        `CHK(r, 32'h0000_0001)
    endtask : t_buf

    task automatic t_ctrl();
        bus(1'b1, ADDR_CTRL, 32'h0000_0000, 1'b0);
        fork
            send(3, 400);
            begin
                repeat (6) @(posedge sys_clk);
                bus(1'b1, ADDR_CTRL, 32'h0000_0002, 1'b0);
                bus(1'b1, ADDR_CTRL, 32'h0000_0001, 1'b0);
            end
        join
        drain();
    endtask : t_ctrl

    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        t_lat();
        t_regs();
        t_stream();
        t_freeze();
        t_buf();
        t_ctrl();
        end_of_test();
    end
endmodule : tb_vector_delay_line

`default_nettype wire
